// ==== rtl/dtl_host.sv ====
// Host controller: plain writes and the offset/gain calibration sequence
`timescale 1ns/1ps
module dtl_host #(
	parameter bit SHARED_PINS = 1'b1
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       wr_req,
	input  wire logic                       wr_trim,
	input  wire logic                       wr_sel_offset,
	input  wire logic [dtl_pkg::MAIN_W-1:0] wr_data,
	input  wire logic                       cal_start,
	input  wire logic                       cal_bipolar,
	input  wire logic                       cmp_valid,
	input  wire logic                       cmp_above,
	input  wire logic [dtl_pkg::MAIN_W-1:0] resume_data,
	output logic                            busy,
	output logic                            done,
	output logic                            cal_active,
	output logic [dtl_pkg::TRIM_W-1:0]      offset_trim,
	output logic [dtl_pkg::TRIM_W-1:0]      gain_trim,
	output logic [dtl_pkg::MAIN_W-1:0]      main_data,
	output logic [dtl_pkg::TRIM_W-1:0]      trim_data,
	output logic                            wr_main_n,
	output logic                            wr_trim_n,
	output logic                            sel_offset
);
	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	typedef struct packed {
		dtl_pkg::dtl_cstate_e         st;
		logic                         pend;
		logic [3:0]                   bitpos;
		logic [dtl_pkg::TRIM_W-1:0]   trial;
		logic [dtl_pkg::TRIM_W-1:0]   offset_trim;
		logic [dtl_pkg::TRIM_W-1:0]   gain_trim;
		logic                         req;
		dtl_pkg::dtl_target_e         target;
		logic [dtl_pkg::MAIN_W-1:0]   data;
		logic                         done;
		logic                         busy;
		logic                         cal;
	} dtl_host_s;

	dtl_host_s h_reg;
	dtl_host_s h_next;
	dtl_wr_if  wr ();

	dtl_strobe #(
		.SHARED_PINS(SHARED_PINS)
	) u_strobe (
		.clk        (clk),
		.rst        (rst),
		.wr         (wr.slave),
		.main_data  (main_data),
		.trim_data  (trim_data),
		.wr_main_n  (wr_main_n),
		.wr_trim_n  (wr_trim_n),
		.sel_offset (sel_offset)
	);

	assign wr.req = h_reg.req;
	assign wr.target = h_reg.target;
	assign wr.data = h_reg.data;

	// Trim search is a binary search, MSB first: 8 trials per trim word
	function automatic logic [dtl_pkg::TRIM_W-1:0] dtl_bit(input logic [3:0] p);
		dtl_bit = dtl_pkg::TRIM_W'(1) << p[2:0];
	endfunction : dtl_bit

	always_comb begin
		h_next = h_reg;
		h_next.req = 1'b0;
		h_next.done = 1'b0;
		case (h_reg.st)
			dtl_pkg::DTL_C_IDLE: begin
				if (!wr.busy && !h_reg.req && !h_reg.pend) begin
					if (cal_start) begin
						// No pend here: only idle clears it, so it would stick past the run
						h_next.st = dtl_pkg::DTL_C_ZERO;
						h_next.req = 1'b1;
						h_next.target = dtl_pkg::DTL_TGT_MAIN;
						h_next.data = cal_bipolar ? dtl_pkg::CODE_MID
							: dtl_pkg::CODE_ZERO;
					end else if (wr_req) begin
						h_next.req = 1'b1;
						h_next.pend = 1'b1;
						h_next.data = wr_data;
						if (!wr_trim)
							h_next.target = dtl_pkg::DTL_TGT_MAIN;
						else if (wr_sel_offset)
							h_next.target = dtl_pkg::DTL_TGT_OFFSET;
						else
							h_next.target = dtl_pkg::DTL_TGT_GAIN;
						if (wr_trim && wr_sel_offset)
							h_next.offset_trim = wr_data[dtl_pkg::TRIM_W-1:0];
						if (wr_trim && !wr_sel_offset)
							h_next.gain_trim = wr_data[dtl_pkg::TRIM_W-1:0];
					end
				end
				if (h_reg.pend && wr.done) begin
					h_next.pend = 1'b0;
					h_next.done = 1'b1;
				end
			end
			dtl_pkg::DTL_C_ZERO, dtl_pkg::DTL_C_FULL: begin
				if (wr.done) begin
					h_next.st = (h_reg.st == dtl_pkg::DTL_C_ZERO) ? dtl_pkg::DTL_C_OFS
						: dtl_pkg::DTL_C_GAIN;
					h_next.bitpos = 4'h7;
					h_next.trial = dtl_pkg::TRIM_MID;
					h_next.req = 1'b1;
					h_next.target = (h_reg.st == dtl_pkg::DTL_C_ZERO)
						? dtl_pkg::DTL_TGT_OFFSET : dtl_pkg::DTL_TGT_GAIN;
					h_next.data = {{(dtl_pkg::MAIN_W-dtl_pkg::TRIM_W){1'b0}},
						dtl_pkg::TRIM_MID};
				end
			end
			dtl_pkg::DTL_C_OFS, dtl_pkg::DTL_C_GAIN: begin
				// Trial is latched; wait for the comparator on the settled output
				if (!wr.busy && !h_reg.req && cmp_valid) begin
					// Above target: raise code, since more code drives output lower
					h_next.trial = cmp_above ? h_reg.trial
						: (h_reg.trial & ~dtl_bit(h_reg.bitpos));
					if (h_reg.bitpos == 4'h0) begin
						if (h_reg.st == dtl_pkg::DTL_C_OFS) begin
							h_next.offset_trim = h_next.trial;
							h_next.st = dtl_pkg::DTL_C_FULL;
							h_next.target = dtl_pkg::DTL_TGT_MAIN;
							h_next.data = dtl_pkg::CODE_FULL;
						end else begin
							h_next.gain_trim = h_next.trial;
							h_next.st = dtl_pkg::DTL_C_RESUME;
							h_next.target = dtl_pkg::DTL_TGT_MAIN;
							h_next.data = resume_data;
						end
						// Final value rewritten so the latch ends on the chosen code
						if (h_next.trial != h_reg.trial) begin
							h_next.req = 1'b1;
							h_next.data = {{(dtl_pkg::MAIN_W-dtl_pkg::TRIM_W){1'b0}},
								h_next.trial};
							h_next.st = h_reg.st;
							h_next.bitpos = 4'hF;
							h_next.target = (h_reg.st == dtl_pkg::DTL_C_OFS)
								? dtl_pkg::DTL_TGT_OFFSET : dtl_pkg::DTL_TGT_GAIN;
						end else begin
							h_next.req = 1'b1;
						end
					end else if (h_reg.bitpos == 4'hF) begin
						h_next.trial = h_reg.trial;
						h_next.bitpos = 4'h0;
					end else begin
						h_next.bitpos = h_reg.bitpos - 4'h1;
						h_next.trial = h_next.trial | dtl_bit(h_reg.bitpos - 4'h1);
						h_next.req = 1'b1;
						h_next.data = {{(dtl_pkg::MAIN_W-dtl_pkg::TRIM_W){1'b0}},
							h_next.trial};
					end
				end
			end
			dtl_pkg::DTL_C_RESUME: begin
				if (wr.done) begin
					h_next.st = dtl_pkg::DTL_C_IDLE;
					h_next.done = 1'b1;
				end
			end
			default: h_next.st = dtl_pkg::DTL_C_IDLE;
		endcase
		h_next.busy = (h_next.st != dtl_pkg::DTL_C_IDLE) || h_next.pend || h_next.req;
		h_next.cal = (h_next.st != dtl_pkg::DTL_C_IDLE);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			h_reg <= '{st: dtl_pkg::DTL_C_IDLE, pend: 1'b0, bitpos: 4'h0, trial: '0,
				offset_trim: '0, gain_trim: '0, req: 1'b0,
				target: dtl_pkg::DTL_TGT_MAIN, data: '0, done: 1'b0, busy: 1'b0,
				cal: 1'b0};
		end else begin
			h_reg <= h_next;
		end
	end

	assign busy = h_reg.busy;
	assign done = h_reg.done;
	assign cal_active = h_reg.cal;
	assign offset_trim = h_reg.offset_trim;
	assign gain_trim = h_reg.gain_trim;
endmodule : dtl_host

// ==== rtl/dtl_pkg.sv ====
// Package: constants, command and state types for the converter load controller
package dtl_pkg;
	localparam int MAIN_W = 16;
	localparam int TRIM_W = 8;
	// Pin timing, ns (setup, pulse width, hold) rounded up to clock cycles
	localparam int CLK_NS = 5;
	localparam int DATA_SETUP_NS = 140;
	localparam int WR_PULSE_NS = 120;
	localparam int DATA_HOLD_NS = 20;
	localparam int SETUP_CYC = (DATA_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (DATA_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int WAIT_CYC = (SETUP_CYC > PULSE_CYC) ? SETUP_CYC : PULSE_CYC;
	localparam int CNT_W = 8;
	// Calibration codes for the main word, and the trim search start code
	localparam logic [MAIN_W-1:0] CODE_ZERO = 16'h0000;
	localparam logic [MAIN_W-1:0] CODE_MID = 16'h8000;
	localparam logic [MAIN_W-1:0] CODE_FULL = 16'hFFFF;
	localparam logic [TRIM_W-1:0] TRIM_MID = 8'h80;

	typedef enum logic [1:0] {
		DTL_TGT_MAIN = 2'h0,
		DTL_TGT_OFFSET = 2'h1,
		DTL_TGT_GAIN = 2'h2
	} dtl_target_e;

	typedef enum logic [1:0] {
		DTL_W_IDLE = 2'h0,
		DTL_W_LOW = 2'h1,
		DTL_W_HOLD = 2'h3
	} dtl_wstate_e;

	typedef enum logic [2:0] {
		DTL_C_IDLE = 3'h0,
		DTL_C_ZERO = 3'h1,
		DTL_C_OFS = 3'h3,
		DTL_C_FULL = 3'h2,
		DTL_C_GAIN = 3'h6,
		DTL_C_RESUME = 3'h7
	} dtl_cstate_e;
endpackage : dtl_pkg

// ==== rtl/dtl_wr_if.sv ====
// Interface: one write request between the sequencer and the strobe engine
`timescale 1ns/1ps
interface dtl_wr_if;
	logic                            req;
	dtl_pkg::dtl_target_e            target;
	logic [dtl_pkg::MAIN_W-1:0]      data;
	logic                            done;
	logic                            busy;
	modport master (output req, output target, output data, input done, input busy);
	modport slave  (input req, input target, input data, output done, output busy);
endinterface : dtl_wr_if

// ==== rtl/dtl_strobe.sv ====
// Strobe engine: drives data, select and one active-low write strobe per request
`timescale 1ns/1ps
module dtl_strobe #(
	parameter bit SHARED_PINS = 1'b1
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	dtl_wr_if.slave                         wr,
	output logic [dtl_pkg::MAIN_W-1:0]      main_data,
	output logic [dtl_pkg::TRIM_W-1:0]      trim_data,
	output logic                            wr_main_n,
	output logic                            wr_trim_n,
	output logic                            sel_offset
);
	typedef struct packed {
		dtl_pkg::dtl_wstate_e         st;
		logic [dtl_pkg::CNT_W-1:0]    cnt;
		logic [dtl_pkg::MAIN_W-1:0]   main_data;
		logic [dtl_pkg::TRIM_W-1:0]   trim_data;
		logic                         wr_main_n;
		logic                         wr_trim_n;
		logic                         sel_offset;
		logic                         done;
	} dtl_strobe_s;

	dtl_strobe_s s_reg;
	dtl_strobe_s s_next;

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		case (s_reg.st)
			dtl_pkg::DTL_W_IDLE: begin
				if (wr.req) begin
					s_next.st = dtl_pkg::DTL_W_LOW;
					s_next.cnt = dtl_pkg::CNT_W'(dtl_pkg::WAIT_CYC - 1);
					if (wr.target == dtl_pkg::DTL_TGT_MAIN) begin
						s_next.main_data = wr.data;
						s_next.wr_main_n = 1'b0;
					end else begin
						s_next.sel_offset = (wr.target == dtl_pkg::DTL_TGT_OFFSET);
						if (SHARED_PINS)
							s_next.main_data[dtl_pkg::TRIM_W-1:0] =
								wr.data[dtl_pkg::TRIM_W-1:0];
						else
							s_next.trim_data = wr.data[dtl_pkg::TRIM_W-1:0];
						s_next.wr_trim_n = 1'b0;
					end
				end
			end
			dtl_pkg::DTL_W_LOW: begin
				if (s_reg.cnt == '0) begin
					// Rising edge captures; data and select held past it
					s_next.wr_main_n = 1'b1;
					s_next.wr_trim_n = 1'b1;
					s_next.st = dtl_pkg::DTL_W_HOLD;
					s_next.cnt = dtl_pkg::CNT_W'(dtl_pkg::HOLD_CYC);
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			dtl_pkg::DTL_W_HOLD: begin
				if (s_reg.cnt == '0) begin
					s_next.st = dtl_pkg::DTL_W_IDLE;
					s_next.done = 1'b1;
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			default: s_next.st = dtl_pkg::DTL_W_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '{st: dtl_pkg::DTL_W_IDLE, cnt: '0, main_data: '0, trim_data: '0,
				wr_main_n: 1'b1, wr_trim_n: 1'b1, sel_offset: 1'b0, done: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign wr.done = s_reg.done;
	assign wr.busy = (s_reg.st != dtl_pkg::DTL_W_IDLE);
	assign main_data = s_reg.main_data;
	assign trim_data = s_reg.trim_data;
	assign wr_main_n = s_reg.wr_main_n;
	assign wr_trim_n = s_reg.wr_trim_n;
	assign sel_offset = s_reg.sel_offset;
endmodule : dtl_strobe

// ==== testbench/dtl_host_properties.sv ====
// Checker: strobe timing, data hold and trim steering seen at the host pins
`timescale 1ns/1ps
module dtl_host_properties #(
	parameter bit SHARED_PINS = 1'b1
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        wr_main_n,
	input wire logic        wr_trim_n,
	input wire logic [15:0] main_data,
	input wire logic [7:0]  trim_data,
	input wire logic        sel_offset,
	input wire logic [7:0]  offset_trim,
	input wire logic [7:0]  gain_trim,
	input wire logic        done,
	input wire logic        cal_active,
	input wire logic        cal_bipolar
);
	logic [7:0] tbus;

	// Trim lines differ by pin form
	assign tbus = SHARED_PINS ? main_data[7:0] : trim_data;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	main_pulse_a: assert property (
		$fell(wr_main_n) |-> ##27 !wr_main_n ##1 wr_main_n) else $error("main strobe width");
	trim_pulse_a: assert property (
		$fell(wr_trim_n) |-> ##27 !wr_trim_n ##1 wr_trim_n) else $error("trim strobe width");
	one_strobe_a: assert property (
		!(!wr_main_n && !wr_trim_n)) else $error("both strobes low");
	main_stable_a: assert property (
		$past(!wr_main_n) |-> $stable(main_data)) else $error("main word moved");
	trim_stable_a: assert property (
		$past(!wr_trim_n) |-> $stable(tbus) && $stable(sel_offset)) else $error("trim moved");
	trim_store_a: assert property (
		$rose(wr_trim_n) && !cal_active
		|-> ##[0:4] ((sel_offset ? offset_trim : gain_trim) == tbus))
		else $error("trim copy wrong");
	done_after_a: assert property (
		($rose(wr_main_n) || $rose(wr_trim_n)) && !cal_active |-> ##6 done)
		else $error("done late");
	done_pulse_a: assert property (
		done |=> !done) else $error("done too long");
	cal_first_a: assert property (
		$rose(cal_active) |-> ##[0:4] ($fell(wr_main_n)
		&& main_data == (cal_bipolar ? dtl_pkg::CODE_MID : dtl_pkg::CODE_ZERO)))
		else $error("first code wrong");
endmodule : dtl_host_properties

bind dtl_host dtl_host_properties #(.SHARED_PINS(SHARED_PINS)) u_props (
	.clk(clk), .rst(rst), .wr_main_n(wr_main_n), .wr_trim_n(wr_trim_n),
	.main_data(main_data), .trim_data(trim_data), .sel_offset(sel_offset),
	.offset_trim(offset_trim), .gain_trim(gain_trim), .done(done),
	.cal_active(cal_active), .cal_bipolar(cal_bipolar));

// ==== testbench/dtl_dev_model.sv ====
// Partner model: converter input latches and a trim comparator
`timescale 1ns/1ps
module dtl_dev_model #(
	parameter bit         SHARED_PINS = 1'b1,
	parameter logic [7:0] OFS_GOAL    = 8'h5A,
	parameter logic [7:0] GAIN_GOAL   = 8'hA7
) (
	input  wire logic        clk,
	input  wire logic        slow,
	input  wire logic [15:0] main_data,
	input  wire logic [7:0]  trim_data,
	input  wire logic        wr_main_n,
	input  wire logic        wr_trim_n,
	input  wire logic        sel_offset,
	output logic             cmp_valid,
	output logic             cmp_above,
	output logic [15:0]      main_lat,
	output logic [7:0]       ofs_lat,
	output logic [7:0]       gain_lat
);
	logic [7:0] tbus;
	logic       last_ofs;
	logic       verdict;
	int         cnt = 0;

	assign tbus = SHARED_PINS ? main_data[7:0] : trim_data;
	always_latch if (!wr_main_n) main_lat <= main_data;
	always_latch begin
		if (!wr_trim_n && sel_offset) ofs_lat <= tbus;
		if (!wr_trim_n && !sel_offset) gain_lat <= tbus;
		if (!wr_trim_n) last_ofs <= sel_offset;
	end
	// Output falls as a trim code rises, so it stays above up to the goal
	assign verdict = last_ofs ? (ofs_lat <= OFS_GOAL) : (gain_lat <= GAIN_GOAL);
	always @(posedge clk) begin
		if (!wr_trim_n) cnt <= 0;
		else if (cnt < 100) cnt <= cnt + 1;
	end
	assign cmp_valid = cnt >= (slow ? 40 : 6);
	// Verdict is shown inverted while invalid
	assign cmp_above = cmp_valid ? verdict : !verdict;
endmodule : dtl_dev_model

// ==== testbench/dac_input_latch_and_trim_load_test.sv ====
// Testbench: plain writes, a refused request and two calibration runs
`timescale 1ns/1ps
module dac_input_latch_and_trim_load_test;
	logic        clk, rst, wr_req, wr_trim, wr_sel_offset, cal_start, cal_bipolar, slow;
	logic        cmp_valid, cmp_above, busy, done, cal_active, wr_main_n, wr_trim_n, sel_offset;
	logic [15:0] wr_data, resume_data, main_data, main_lat;
	logic [7:0]  offset_trim, gain_trim, trim_data, ofs_lat, gain_lat;
	int          n_mismatch, checks_done, cycles;
	logic        busy_s, done_s, cal_s, wrm_s_n, wrt_s_n, sel_s, cmp_valid_s, cmp_above_s;
	logic [15:0] main_data_s, main_lat_s;
	logic [7:0]  ofs_trim_s, gain_trim_s, trim_data_s, ofs_lat_s, gain_lat_s;

	dtl_host #(.SHARED_PINS(1'b1)) dut (
		.clk(clk), .rst(rst), .wr_req(wr_req), .wr_trim(wr_trim),
		.wr_sel_offset(wr_sel_offset), .wr_data(wr_data), .cal_start(cal_start),
		.cal_bipolar(cal_bipolar), .cmp_valid(cmp_valid), .cmp_above(cmp_above),
		.resume_data(resume_data), .busy(busy), .done(done), .cal_active(cal_active),
		.offset_trim(offset_trim), .gain_trim(gain_trim), .main_data(main_data),
		.trim_data(trim_data), .wr_main_n(wr_main_n), .wr_trim_n(wr_trim_n),
		.sel_offset(sel_offset));
	dtl_dev_model #(.SHARED_PINS(1'b1)) model (
		.clk(clk), .slow(slow), .main_data(main_data), .trim_data(trim_data),
		.wr_main_n(wr_main_n), .wr_trim_n(wr_trim_n), .sel_offset(sel_offset),
		.cmp_valid(cmp_valid), .cmp_above(cmp_above), .main_lat(main_lat),
		.ofs_lat(ofs_lat), .gain_lat(gain_lat));
	// Same stimulus into the separate-pin form, with its own far side
	dtl_host #(.SHARED_PINS(1'b0)) dut_sep (
		.clk(clk), .rst(rst), .wr_req(wr_req), .wr_trim(wr_trim),
		.wr_sel_offset(wr_sel_offset), .wr_data(wr_data), .cal_start(cal_start),
		.cal_bipolar(cal_bipolar), .cmp_valid(cmp_valid_s), .cmp_above(cmp_above_s),
		.resume_data(resume_data), .busy(busy_s), .done(done_s), .cal_active(cal_s),
		.offset_trim(ofs_trim_s), .gain_trim(gain_trim_s), .main_data(main_data_s),
		.trim_data(trim_data_s), .wr_main_n(wrm_s_n), .wr_trim_n(wrt_s_n),
		.sel_offset(sel_s));
	dtl_dev_model #(.SHARED_PINS(1'b0)) model_sep (
		.clk(clk), .slow(slow), .main_data(main_data_s), .trim_data(trim_data_s),
		.wr_main_n(wrm_s_n), .wr_trim_n(wrt_s_n), .sel_offset(sel_s),
		.cmp_valid(cmp_valid_s), .cmp_above(cmp_above_s), .main_lat(main_lat_s),
		.ofs_lat(ofs_lat_s), .gain_lat(gain_lat_s));

	always #2.5 clk = ~clk;

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	task automatic wait_done(input int lim);
		int i;
		i = 0;
		while (done !== 1'b1 && i < lim) begin
			@(negedge clk);
			i++;
		end
		chk("done", 16'h0001, {15'h0000, done});
		chk("sep done", 16'h0001, {15'h0000, done_s});
	endtask : wait_done

	task automatic put(input logic t, input logic s, input logic [15:0] d);
		@(negedge clk);
		wr_req = 1'b1;
		wr_trim = t;
		wr_sel_offset = s;
		wr_data = d;
		@(negedge clk);
		wr_req = 1'b0;
		wait_done(100);
	endtask : put

	task automatic t_writes();
		put(1'b0, 1'b0, 16'hA5C3);
		chk("main latch", 16'hA5C3, main_lat);
		put(1'b1, 1'b1, 16'h003C);
		put(1'b1, 1'b0, 16'h00FF);
		chk("offset latch", 16'h003C, {8'h00, ofs_lat});
		chk("gain latch", 16'h00FF, {8'h00, gain_lat});
		chk("offset out", 16'h003C, {8'h00, offset_trim});
		chk("shared trim bus", 16'h0000, {8'h00, trim_data});
		chk("sep offset latch", 16'h003C, {8'h00, ofs_lat_s});
		chk("sep gain latch", 16'h00FF, {8'h00, gain_lat_s});
		chk("sep trim bus", 16'h00FF, {8'h00, trim_data_s});
		chk("sep main lines", 16'hA5C3, main_data_s);
		chk("sep main latch", 16'hA5C3, main_lat_s);
		chk("gain out", 16'h00FF, {8'h00, gain_trim});
		chk("main kept", 16'hA5C3, main_lat);
		chk("upper lines", 16'h00A5, {8'h00, main_data[15:8]});
	endtask : t_writes

	task automatic t_refuse();
		@(negedge clk);
		wr_req = 1'b1;
		wr_trim = 1'b1;
		wr_sel_offset = 1'b0;
		wr_data = 16'h0011;
		@(negedge clk);
		wr_req = 1'b0;
		repeat (10) @(negedge clk);
		wr_req = 1'b1;
		wr_trim = 1'b0;
		wr_data = 16'h1234;
		@(negedge clk);
		wr_req = 1'b0;
		wait_done(100);
		repeat (50) @(negedge clk);
		chk("busy idle", 16'h0000, {15'h0000, busy});
		chk("sep busy idle", 16'h0000, {15'h0000, busy_s});
		chk("main kept", 16'hA5C3, main_lat);
		chk("gain latch", 16'h0011, {8'h00, gain_lat});
	endtask : t_refuse

	task automatic t_cal(input logic bip, input logic sl, input logic [15:0] res);
		@(negedge clk);
		slow = sl;
		cal_bipolar = bip;
		resume_data = res;
		cal_start = 1'b1;
		@(negedge clk);
		cal_start = 1'b0;
		wait_done(4000);
		chk("offset result", 16'h005A, {8'h00, offset_trim});
		chk("gain result", 16'h00A7, {8'h00, gain_trim});
		chk("offset latch", 16'h005A, {8'h00, ofs_lat});
		chk("gain latch", 16'h00A7, {8'h00, gain_lat});
		chk("resume word", res, main_lat);
		chk("sep trims", 16'h5AA7, {ofs_trim_s, gain_trim_s});
		chk("sep offset latch", 16'h005A, {8'h00, ofs_lat_s});
		chk("sep gain latch", 16'h00A7, {8'h00, gain_lat_s});
		chk("sep resume word", res, main_lat_s);
		@(negedge clk);
		chk("cal idle", 16'h0000, {15'h0000, cal_active});
		chk("sep cal idle", 16'h0000, {15'h0000, cal_s});
	endtask : t_cal

	// Ceiling well above the few thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		wr_req = 1'b0;
		wr_trim = 1'b0;
		wr_sel_offset = 1'b0;
		wr_data = 16'h0000;
		cal_start = 1'b0;
		cal_bipolar = 1'b0;
		slow = 1'b0;
		resume_data = 16'h0000;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		t_writes();
		t_refuse();
		t_cal(1'b0, 1'b0, 16'h1357);
		t_cal(1'b1, 1'b1, 16'hFFFF);
		tally_and_finish();
	end
endmodule : dac_input_latch_and_trim_load_test
